// File: shared/abu_pkg.sv
// Package for the address breakpoint unit: register map, field layout, vectors, types.
// Assumes an Avalon-MM slave with byte-wide registers in the low bits of 32-bit words.
package abu_pkg;

  // Printed offsets are not all multiples of four, so they are register indices.
  localparam logic [15:0] ABU_IDX_ADDR_HIGH = 16'hFE0C;
  localparam logic [15:0] ABU_IDX_ADDR_LOW  = 16'hFE0D;
  localparam logic [15:0] ABU_IDX_CTRL_STAT = 16'hFE0E;
  localparam logic [15:0] ABU_IDX_FLAG_CTRL = 16'hFE0F;
  localparam int          ABU_ADDR_W        = 18;

  // Field positions.
  localparam int ABU_BIT_MATCH_EN   = 7;
  localparam int ABU_BIT_ACTIVE     = 6;
  localparam int ABU_BIT_FLAG_CLR   = 7;

  // Reset values.
  localparam logic [7:0] ABU_RST_BYTE = 8'h00;

  // Break vector pairs.
  localparam logic [15:0] ABU_VEC_USER_HI = 16'hFFFC;
  localparam logic [15:0] ABU_VEC_USER_LO = 16'hFFFD;
  localparam logic [15:0] ABU_VEC_MON_HI  = 16'hFEFC;
  localparam logic [15:0] ABU_VEC_MON_LO  = 16'hFEFD;

  // Opcode forced into the instruction register; value is a plain default.
  localparam logic [7:0] ABU_SWI_OPCODE = 8'h83;

  // Register bus request bundle.
  typedef struct packed {
    logic [ABU_ADDR_W-1:0] address;
    logic                  read;
    logic                  write;
    logic [31:0]           writedata;
    logic [3:0]            byteenable;
  } abu_req_t;

  // Core-side status bundle.
  typedef struct packed {
    logic [15:0] addr;
    logic        addr_valid;
    logic        last_cycle;
    logic        rti_done;
    logic        monitor_mode;
    logic        stop_mode;
    logic        wait_mode;
    logic        high_volt;
  } abu_core_t;

  // Break sequencer states.
  typedef enum logic [1:0] {
    ABU_IDLE    = 2'b00,
    ABU_PENDING = 2'b01,
    ABU_ACTIVE  = 2'b10
  } abu_state_t;

endpackage : abu_pkg

// File: src/abu_sync.sv
// Two-stage synchroniser for a level from outside the clock domain.
// Assumes the level is slow against the 50 MHz clock.
`timescale 1ns/1ns
module abu_sync (
  input  wire logic CLK_IN,
  input  wire logic RST_N_IN,
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      meta_r <= 1'b0;
      q_out  <= 1'b0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule : abu_sync

// File: src/abu_match.sv
// Combinational comparator of the core address against the breakpoint address.
// Assumes the address and its valid flag come from logic on the same clock.
`timescale 1ns/1ns
module abu_match #(
  parameter int ADDR_W = 16
) (
  input  wire logic              CLK_IN,
  input  wire logic              RST_N_IN,
  input  wire logic              enable_in,
  input  wire logic              valid_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [ADDR_W-1:0] target_in,
  output logic                   hit_out
);
  // Combinational so the hit lands in the same cycle as the address.
  always_comb begin
    hit_out = enable_in && valid_in && (addr_in == target_in);
  end
  logic unused_clk;
  assign unused_clk = CLK_IN ^ RST_N_IN;
endmodule : abu_match

// File: src/abu_top.sv
// Address breakpoint unit: registers, match, break sequencer and core side-effects.
// Assumes a core that reports its fetch address, instruction end and return from
// interrupt on this clock, and an Avalon-MM master on the same clock.
//
// How it works
// - Flag breakpoint when core address equals target.
// - After instruction, force opcode, fetch user vectors.
// - Monitor mode selects the alternate vector pair.
// - Writing one to active flag raises break.
// - Match on final cycle starts break immediately.
// - Return from interrupt ends the break state.
// - Timer counter held while break in progress.
// - Watchdog disabled in break under high voltage.
// - Flag clear enable gates peripheral flag clearing.
// - Unit works in wait; records wait exit.
// - Stop mode blocks address matching, registers kept.
// - Bit seven enables address match breaks.
// - Match sets flag; software clears, reset clears.
// - Address byte registers reset to zero.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ns
module abu_top (
  input  wire logic                        CLK_IN,
  input  wire logic                        RST_N_IN,
  input  wire logic [abu_pkg::ABU_ADDR_W-1:0] AVS_ADDRESS_IN,
  input  wire logic                        AVS_READ_IN,
  input  wire logic                        AVS_WRITE_IN,
  input  wire logic [31:0]                 AVS_WRITEDATA_IN,
  input  wire logic [3:0]                  AVS_BYTEENABLE_IN,
  output logic [31:0]                      AVS_READDATA_OUT,
  output logic                             AVS_WAITREQUEST_OUT,
  input  wire logic [15:0]                 CORE_ADDR_IN,
  input  wire logic                        CORE_ADDR_VALID_IN,
  input  wire logic                        CORE_LAST_CYCLE_IN,
  input  wire logic                        CORE_RTI_IN,
  input  wire logic                        MONITOR_MODE_IN,
  input  wire logic                        STOP_MODE_IN,
  input  wire logic                        WAIT_MODE_IN,
  input  wire logic                        HIGH_VOLT_RESET_IN,
  output logic                             BREAK_REQ_OUT,
  output logic                             FORCE_OPCODE_OUT,
  output logic [7:0]                       OPCODE_OUT,
  output logic [15:0]                      VECTOR_HI_OUT,
  output logic [15:0]                      VECTOR_LO_OUT,
  output logic                             BREAK_ACTIVE_OUT,
  output logic                             TIMER_HOLD_OUT,
  output logic                             WATCHDOG_HOLD_OUT,
  output logic                             FLAG_CLEAR_ALLOW_OUT,
  output logic                             WAIT_EXIT_BY_BREAK_OUT
);
  import abu_pkg::*;

  abu_req_t   req;
  abu_core_t  core;
  abu_state_t state_r;
  abu_state_t state_nxt;
  logic [7:0] break_address_high_r;
  logic [7:0] break_address_low_r;
  logic       break_match_enable_r;
  logic       break_active_flag_r;
  logic       flag_clear_enable_r;
  logic       wait_exit_by_break_r;
  logic       ack_r;
  logic       high_volt_sync;
  logic       hit;
  logic       sw_break;
  logic       wr_ctrl;
  logic       wr_lane0;
  logic       start_now;
  logic       break_event;

  // Decode a register index from the byte address.
  function automatic logic sel(input logic [ABU_ADDR_W-1:0] a, input logic [15:0] idx);
    sel = (a[ABU_ADDR_W-1:2] == idx);
  endfunction : sel

  // Gather bus and core signals into bundles.
  always_comb begin
    req.address    = AVS_ADDRESS_IN;
    req.read       = AVS_READ_IN;
    req.write      = AVS_WRITE_IN;
    req.writedata  = AVS_WRITEDATA_IN;
    req.byteenable = AVS_BYTEENABLE_IN;
    core.addr         = CORE_ADDR_IN;
    core.addr_valid   = CORE_ADDR_VALID_IN;
    core.last_cycle   = CORE_LAST_CYCLE_IN;
    core.rti_done     = CORE_RTI_IN;
    core.monitor_mode = MONITOR_MODE_IN;
    core.stop_mode    = STOP_MODE_IN;
    core.wait_mode    = WAIT_MODE_IN;
    core.high_volt    = high_volt_sync;
  end

  // The test voltage detector is an analogue pin, so it is synchronised.
  abu_sync u_hv_sync (
    .CLK_IN   (CLK_IN),
    .RST_N_IN (RST_N_IN),
    .d_in     (HIGH_VOLT_RESET_IN),
    .q_out    (high_volt_sync)
  );

  // Matching stops in stop mode but continues in wait mode.
  abu_match #(.ADDR_W(16)) u_match (
    .CLK_IN    (CLK_IN),
    .RST_N_IN  (RST_N_IN),
    .enable_in (break_match_enable_r && !core.stop_mode),
    .valid_in  (core.addr_valid),
    .addr_in   (core.addr),
    .target_in ({break_address_high_r, break_address_low_r}),
    .hit_out   (hit)
  );

  // Every access takes one wait cycle; the answer comes on the second edge.
  assign AVS_WAITREQUEST_OUT = (req.read || req.write) && !ack_r;
  assign wr_lane0 = req.write && ack_r && req.byteenable[0];
  assign wr_ctrl  = wr_lane0 && sel(req.address, ABU_IDX_CTRL_STAT);
  assign sw_break = wr_ctrl && req.writedata[ABU_BIT_ACTIVE];

  // Acknowledge toggle, so back-to-back requests each see one wait cycle.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (req.read || req.write) && !ack_r;
    end
  end

  // Address byte registers; stop mode does not disturb their contents.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      break_address_high_r <= ABU_RST_BYTE;
      break_address_low_r  <= ABU_RST_BYTE;
    end else begin
      if (wr_lane0 && sel(req.address, ABU_IDX_ADDR_HIGH)) begin
        break_address_high_r <= req.writedata[7:0];
      end
      if (wr_lane0 && sel(req.address, ABU_IDX_ADDR_LOW)) begin
        break_address_low_r <= req.writedata[7:0];
      end
    end
  end

  // Match enable bit; only bits seven and six of the control register exist.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      break_match_enable_r <= 1'b0;
    end else if (wr_ctrl) begin
      break_match_enable_r <= req.writedata[ABU_BIT_MATCH_EN];
    end
  end

  // Active flag: a hardware set wins over a software clear in the same cycle.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      break_active_flag_r <= 1'b0;
    end else if (hit || sw_break) begin
      break_active_flag_r <= 1'b1;
    end else if (wr_ctrl && !req.writedata[ABU_BIT_ACTIVE]) begin
      break_active_flag_r <= 1'b0;
    end
  end

  // Flag-clear enable in the separate flag control register.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      flag_clear_enable_r <= 1'b0;
    end else if (wr_lane0 && sel(req.address, ABU_IDX_FLAG_CTRL)) begin
      flag_clear_enable_r <= req.writedata[ABU_BIT_FLAG_CLR];
    end
  end

  // A break from either source; a final-cycle match skips the pending wait.
  assign break_event = hit || sw_break;
  assign start_now   = break_event && core.last_cycle;

  // Break sequencer: pending until the instruction ends, active until return.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ABU_IDLE: begin
        if (start_now) begin
          state_nxt = ABU_ACTIVE;
        end else if (break_event) begin
          state_nxt = ABU_PENDING;
        end
      end
      ABU_PENDING: begin
        if (core.last_cycle) begin
          state_nxt = ABU_ACTIVE;
        end
      end
      ABU_ACTIVE: begin
        if (core.rti_done) begin
          state_nxt = ABU_IDLE;
        end
      end
      default: begin
        state_nxt = ABU_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_r <= ABU_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Wait exit status: set when a break arrives during wait, cleared by a read
  // of the flag control register index.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      wait_exit_by_break_r <= 1'b0;
    end else if (break_event && core.wait_mode) begin
      wait_exit_by_break_r <= 1'b1;
    end else if (req.read && ack_r && sel(req.address, ABU_IDX_FLAG_CTRL)) begin
      wait_exit_by_break_r <= 1'b0;
    end
  end

  // Opcode force and vector outputs, registered so the core sees clean levels.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      FORCE_OPCODE_OUT <= 1'b0;
      VECTOR_HI_OUT    <= ABU_VEC_USER_HI;
      VECTOR_LO_OUT    <= ABU_VEC_USER_LO;
    end else begin
      FORCE_OPCODE_OUT <= (state_r != ABU_ACTIVE) && (state_nxt == ABU_ACTIVE);
      VECTOR_HI_OUT    <= core.monitor_mode ? ABU_VEC_MON_HI : ABU_VEC_USER_HI;
      VECTOR_LO_OUT    <= core.monitor_mode ? ABU_VEC_MON_LO : ABU_VEC_USER_LO;
    end
  end

  assign OPCODE_OUT             = ABU_SWI_OPCODE;
  assign BREAK_REQ_OUT          = break_event || (state_r == ABU_PENDING);
  assign BREAK_ACTIVE_OUT       = (state_r == ABU_ACTIVE);
  assign TIMER_HOLD_OUT         = (state_r == ABU_ACTIVE);
  assign WATCHDOG_HOLD_OUT      = (state_r == ABU_ACTIVE) && core.high_volt;
  assign FLAG_CLEAR_ALLOW_OUT   = (state_r != ABU_ACTIVE) || flag_clear_enable_r;
  assign WAIT_EXIT_BY_BREAK_OUT = wait_exit_by_break_r;

  // Read data: registered on the wait edge, ready for the acknowledge; unmapped reads zero.
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      AVS_READDATA_OUT <= 32'h0000_0000;
    end else if (req.read && !ack_r) begin
      AVS_READDATA_OUT <= 32'h0000_0000;
      if (sel(req.address, ABU_IDX_ADDR_HIGH)) begin
        AVS_READDATA_OUT[7:0] <= break_address_high_r;
      end else if (sel(req.address, ABU_IDX_ADDR_LOW)) begin
        AVS_READDATA_OUT[7:0] <= break_address_low_r;
      end else if (sel(req.address, ABU_IDX_CTRL_STAT)) begin
        AVS_READDATA_OUT[ABU_BIT_MATCH_EN] <= break_match_enable_r;
        AVS_READDATA_OUT[ABU_BIT_ACTIVE]   <= break_active_flag_r;
      end else if (sel(req.address, ABU_IDX_FLAG_CTRL)) begin
        AVS_READDATA_OUT[ABU_BIT_FLAG_CLR] <= flag_clear_enable_r;
        AVS_READDATA_OUT[0]                <= wait_exit_by_break_r;
      end
    end
  end

endmodule : abu_top

// File: sim/abu_core_model.sv
// Core stand-in: runs three-cycle instructions from BASE and takes the break vectors.
// Assumes the bench starts and stops the run and asks for the return itself.
`timescale 1ns/1ns
module abu_core_model #(
  parameter logic [15:0] BASE = 16'h1240
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        run_in,
  input  wire logic        rti_req_in,
  input  wire logic        force_in,
  input  wire logic [15:0] vec_hi_in,
  input  wire logic [15:0] vec_lo_in,
  output logic [15:0]      addr_out,
  output logic             valid_out,
  output logic             last_out,
  output logic             rti_out,
  output logic [31:0]      fetch_out
);
  logic [1:0] ph_r;

  // The third cycle of each instruction is its last.
  assign last_out = valid_out && ph_r == 2'h2;

  // An idle bus toggles, so a stale address never passes for a live one.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_out  <= 16'h0000;
      ph_r      <= 2'h0;
      valid_out <= 1'b0;
    end else begin
      addr_out  <= !run_in ? ~addr_out : valid_out ? addr_out + 16'h0001 : BASE;
      ph_r      <= (!valid_out || ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
      valid_out <= run_in;
    end
  end

  // Vectors are taken while the opcode is forced; the return follows a request.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fetch_out <= 32'h00000000;
      rti_out   <= 1'b0;
    end else begin
      if (force_in) begin
        fetch_out <= {vec_hi_in, vec_lo_in};
      end
      rti_out <= rti_req_in;
    end
  end
endmodule : abu_core_model

// File: sim/abu_checker.sv
// Checker for the breakpoint unit: sequencer timing and the side outputs to the core.
// Assumes it is bound into the unit's top module and sees only its ports.
`timescale 1ns/1ns
module abu_checker
  import abu_pkg::*;
(
  input wire logic        CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic        AVS_READ_IN,
  input wire logic        CORE_LAST_CYCLE_IN,
  input wire logic        CORE_RTI_IN,
  input wire logic        MONITOR_MODE_IN,
  input wire logic        HIGH_VOLT_RESET_IN,
  input wire logic        BREAK_REQ_OUT,
  input wire logic        FORCE_OPCODE_OUT,
  input wire logic [15:0] VECTOR_HI_OUT,
  input wire logic        BREAK_ACTIVE_OUT,
  input wire logic        TIMER_HOLD_OUT,
  input wire logic        WATCHDOG_HOLD_OUT,
  input wire logic        FLAG_CLEAR_ALLOW_OUT,
  input wire logic        WAIT_EXIT_BY_BREAK_OUT
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  a_last_active: assert property (
    BREAK_REQ_OUT && CORE_LAST_CYCLE_IN && !BREAK_ACTIVE_OUT |=> BREAK_ACTIVE_OUT)
    else $error("break did not start at instruction end");
  a_force_pulse: assert property (
    $rose(BREAK_ACTIVE_OUT) |-> FORCE_OPCODE_OUT ##1 !FORCE_OPCODE_OUT)
    else $error("opcode force was not a single pulse after break start");
  a_rti_ends: assert property (BREAK_ACTIVE_OUT && CORE_RTI_IN |=> !BREAK_ACTIVE_OUT)
    else $error("return did not end the break");
  a_timer_hold: assert property (TIMER_HOLD_OUT == BREAK_ACTIVE_OUT)
    else $error("timer hold differs from break state");
  a_wdog_hold: assert property (
    WATCHDOG_HOLD_OUT == (BREAK_ACTIVE_OUT && $past(HIGH_VOLT_RESET_IN, 2)))
    else $error("watchdog hold wrong");
  a_vec_sel: assert property (
    VECTOR_HI_OUT == ($past(MONITOR_MODE_IN) ? ABU_VEC_MON_HI : ABU_VEC_USER_HI))
    else $error("break vector does not follow mode");
  a_flag_allow: assert property (!BREAK_ACTIVE_OUT |-> FLAG_CLEAR_ALLOW_OUT)
    else $error("flag clearing blocked outside break");
  a_wait_sticky: assert property (
    WAIT_EXIT_BY_BREAK_OUT && !AVS_READ_IN |=> WAIT_EXIT_BY_BREAK_OUT)
    else $error("wait exit record lost without a read");

  // Main scenarios: monitor-mode break, watchdog hold, wait exit record.
  c_mon_break: cover property ($rose(BREAK_ACTIVE_OUT) && VECTOR_HI_OUT == ABU_VEC_MON_HI);
  c_wdog: cover property (WATCHDOG_HOLD_OUT);
  c_wait: cover property ($rose(WAIT_EXIT_BY_BREAK_OUT));
endmodule : abu_checker

bind abu_top abu_checker chk (.*);

// File: sim/test_abu_top.sv
// Bench for the breakpoint unit: registers, address breaks, software break, modes.
// Assumes the core stand-in and the checker are compiled before it.
`timescale 1ns/1ns
module test_abu_top;
  import abu_pkg::*;
  logic [ABU_ADDR_W-1:0] AVS_ADDRESS_IN = '0;
  logic [31:0] AVS_WRITEDATA_IN = '0, AVS_READDATA_OUT, fetch, q;
  logic [3:0]  AVS_BYTEENABLE_IN = 4'h1;
  logic [15:0] CORE_ADDR_IN, VECTOR_HI_OUT, VECTOR_LO_OUT;
  logic [7:0]  OPCODE_OUT;
  logic CLK_IN = 1'b0, RST_N_IN = 1'b0, AVS_READ_IN = 1'b0, AVS_WRITE_IN = 1'b0;
  logic MONITOR_MODE_IN = 1'b0, STOP_MODE_IN = 1'b0, WAIT_MODE_IN = 1'b0;
  logic HIGH_VOLT_RESET_IN = 1'b0, run = 1'b0, return_from_interrupt = 1'b0, AVS_WAITREQUEST_OUT;
  logic CORE_ADDR_VALID_IN, CORE_LAST_CYCLE_IN, CORE_RTI_IN, BREAK_REQ_OUT;
  logic FORCE_OPCODE_OUT, BREAK_ACTIVE_OUT, TIMER_HOLD_OUT, WATCHDOG_HOLD_OUT;
  logic FLAG_CLEAR_ALLOW_OUT, WAIT_EXIT_BY_BREAK_OUT;
  int   fail_count = 0, checked = 0, cyc = 0;

  abu_top DUT (.*);
  abu_core_model partner (
    .clk_in     (CLK_IN),
    .rst_n_in   (RST_N_IN),
    .run_in     (run),
    .rti_req_in (return_from_interrupt),
    .force_in   (FORCE_OPCODE_OUT),
    .vec_hi_in  (VECTOR_HI_OUT),
    .vec_lo_in  (VECTOR_LO_OUT),
    .addr_out   (CORE_ADDR_IN),
    .valid_out  (CORE_ADDR_VALID_IN),
    .last_out   (CORE_LAST_CYCLE_IN),
    .rti_out    (CORE_RTI_IN),
    .fetch_out  (fetch)
  );

  // Clock at 50 MHz.
  initial forever #10 CLK_IN = ~CLK_IN;

  task automatic conclude;
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // A hung wait is cut short here; the whole run needs well under a thousand cycles.
  always @(posedge CLK_IN) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      $display("Error %0t: timeout", $time);
      conclude();
    end
  end

  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : ck

  // One transfer; the request stands until waitrequest is low at a rising edge.
  task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d);
    @(posedge CLK_IN);
    AVS_ADDRESS_IN   <= {idx, 2'b00};
    AVS_WRITEDATA_IN <= {24'h000000, d};
    AVS_WRITE_IN     <= w;
    AVS_READ_IN      <= !w;
    // Waitrequest and read data are taken at the rising edge, before it updates them.
    do @(posedge CLK_IN); while (AVS_WAITREQUEST_OUT !== 1'b0);
    q = AVS_READDATA_OUT;
    AVS_WRITE_IN <= 1'b0;
    AVS_READ_IN  <= 1'b0;
  endtask : bus

  task automatic rdck(input logic [15:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    ck(q, {24'h000000, exp});
  endtask : rdck

  // Waits a bounded time for the break state to reach v, at a settled point.
  task automatic waitact(input logic v);
    int n;
    n = 0;
    @(negedge CLK_IN);
    while (BREAK_ACTIVE_OUT !== v && n < 20) begin
      n++;
      @(negedge CLK_IN);
    end
    ck(BREAK_ACTIVE_OUT, v);
  endtask : waitact

  initial begin
    repeat (3) @(posedge CLK_IN);
    RST_N_IN <= 1'b1;
    rdck(ABU_IDX_ADDR_HIGH, 8'h00);
    rdck(ABU_IDX_ADDR_LOW, 8'h00);
    rdck(ABU_IDX_CTRL_STAT, 8'h00);
    bus(1'b1, ABU_IDX_ADDR_HIGH, 8'h12);
    bus(1'b1, ABU_IDX_CTRL_STAT, 8'hBF);
    rdck(ABU_IDX_CTRL_STAT, 8'h80);
    bus(1'b1, 16'hFE10, 8'h5A);
    rdck(16'hFE10, 8'h00);
    // Match at an instruction's first cycle, its last, and the middle cycle of the next.
    for (int k = 0; k < 6; k += 2) begin
      bus(1'b1, ABU_IDX_ADDR_LOW, 8'h40 + k);
      MONITOR_MODE_IN <= (k == 4);
      run             <= 1'b1;
      waitact(1'b1);
      ck(CORE_ADDR_IN - 16'h1240, (k == 4) ? 32'h6 : 32'h3);
      @(posedge CLK_IN);
      run <= 1'b0;
      rdck(ABU_IDX_CTRL_STAT, 8'hC0);
      ck(fetch, (k == 4) ? {ABU_VEC_MON_HI, ABU_VEC_MON_LO}
                         : {ABU_VEC_USER_HI, ABU_VEC_USER_LO});
      ck(OPCODE_OUT, ABU_SWI_OPCODE);
      ck(TIMER_HOLD_OUT, 1'b1);
      bus(1'b1, ABU_IDX_CTRL_STAT, 8'h80);
      rdck(ABU_IDX_CTRL_STAT, 8'h80);
      return_from_interrupt <= 1'b1;
      @(posedge CLK_IN);
      return_from_interrupt <= 1'b0;
      waitact(1'b0);
      ck(TIMER_HOLD_OUT, 1'b0);
    end
    // A match must not break while disabled, nor in stop mode.
    for (int c = 0; c < 2; c++) begin
      bus(1'b1, ABU_IDX_ADDR_LOW, 8'h41);
      bus(1'b1, ABU_IDX_CTRL_STAT, (c == 1) ? 8'h80 : 8'h00);
      STOP_MODE_IN <= (c == 1);
      run          <= 1'b1;
      repeat (10) @(negedge CLK_IN);
      ck(BREAK_ACTIVE_OUT, 1'b0);
      @(posedge CLK_IN);
      run          <= 1'b0;
      STOP_MODE_IN <= 1'b0;
      rdck(ABU_IDX_ADDR_LOW, 8'h41);
      rdck(ABU_IDX_CTRL_STAT, (c == 1) ? 8'h80 : 8'h00);
    end
    // Software break in wait mode with the test voltage present.
    WAIT_MODE_IN       <= 1'b1;
    HIGH_VOLT_RESET_IN <= 1'b1;
    bus(1'b1, ABU_IDX_CTRL_STAT, 8'h40);
    run <= 1'b1;
    waitact(1'b1);
    @(posedge CLK_IN);
    run          <= 1'b0;
    WAIT_MODE_IN <= 1'b0;
    repeat (3) @(negedge CLK_IN);
    ck(WATCHDOG_HOLD_OUT, 1'b1);
    ck(WAIT_EXIT_BY_BREAK_OUT, 1'b1);
    ck(FLAG_CLEAR_ALLOW_OUT, 1'b0);
    bus(1'b1, ABU_IDX_FLAG_CTRL, 8'h80);
    rdck(ABU_IDX_FLAG_CTRL, 8'h81);
    ck(FLAG_CLEAR_ALLOW_OUT, 1'b1);
    rdck(ABU_IDX_FLAG_CTRL, 8'h80);
    rdck(ABU_IDX_CTRL_STAT, 8'h40);
    bus(1'b1, ABU_IDX_CTRL_STAT, 8'h00);
    return_from_interrupt <= 1'b1;
    @(posedge CLK_IN);
    return_from_interrupt <= 1'b0;
    waitact(1'b0);
    conclude();
  end
endmodule : test_abu_top
